// ### shared/eel_pkg.sv
`default_nettype none
package eel_pkg;
   // Register byte addresses (printed offsets are not all multiples of four: index * 4)
   localparam logic [7:0] ERR_ENABLE_IDX = 8'hCA;
   localparam logic [9:0] ADDR_STATUS = 10'h0000;
   localparam logic [9:0] ADDR_ENABLE = {ERR_ENABLE_IDX, 2'b00};
   localparam logic [9:0] ADDR_LOG_ADDR = 10'h0004;
   localparam logic [9:0] ADDR_LOG_INFO = 10'h0008;
   localparam logic [9:0] ADDR_CONTROL = 10'h000C;
   localparam logic [9:0] ADDR_IRQ_STATUS = 10'h0010;
   localparam logic [9:0] ADDR_IRQ_MASK = 10'h0014;
   // Widths
   localparam int LOG_ADDR_W = 32;
   localparam int CHAN_W = 2;
   localparam int DEV_W = 6;
   localparam int EVT_W = 8;
   // Reset value and write masks
   localparam logic [15:0] ENABLE_RESET = 16'h0000;
   localparam logic [15:0] ENABLE_WMASK = 16'hF601;
   localparam logic [15:0] ENABLE_WMASK_FULL = 16'hF603;
   // Enable bit positions
   localparam int EN_SBE = 0;
   localparam int EN_MBE = 1;
   localparam int EN_LOCK = 9;
   localparam int EN_THERM = 10;
   localparam int EN_DSTB = 12;
   localparam int EN_ASTB = 13;
   localparam int EN_DPAR = 14;
   localparam int EN_RPAR = 15;
   // Event vector positions (interrupt status and internal event bus)
   localparam int EV_SBE = 0;
   localparam int EV_MBE = 1;
   localparam int EV_RPAR = 2;
   localparam int EV_DPAR = 3;
   localparam int EV_ASTB = 4;
   localparam int EV_DSTB = 5;
   localparam int EV_THERM = 6;
   localparam int EV_LOCK = 7;
   // Error type encodings for the log
   localparam logic [1:0] ETYPE_NONE = 2'h0;
   localparam logic [1:0] ETYPE_SINGLE = 2'h1;
   localparam logic [1:0] ETYPE_MULTI = 2'h2;

   typedef struct packed {
      logic valid;
      logic multiBit;
      logic [LOG_ADDR_W-1:0] addr;
      logic [CHAN_W-1:0] chan;
      logic [DEV_W-1:0] dev;
   } eel_ecc_s;

   typedef struct packed {
      logic [LOG_ADDR_W-1:0] addr;
      logic [CHAN_W-1:0] chan;
      logic [DEV_W-1:0] dev;
      logic [1:0] etype;
   } eel_log_s;
endpackage
`default_nettype wire

// ### logic/eel_error_log.sv
// Behaviour
// - Multi-bit error sets bit1, logs details
// - Multi-bit flag set freezes log
// - Write one clears multi-bit flag, unlocks
// - Single-bit error sets bit0, logs details
// - Single-bit flag blocks further single-bit logging
// - Multi-bit overrides single-bit lock, sets flag
// - Single-bit flag write-one-clear, unlocks log
// - Enabled flag set sends error message
// - Messages need global command enable
// - Bit15 enables request parity messages
// - Bit14 enables data parity messages
// - Bit13 enables address strobe glitch messages
// - Bit12 enables data strobe glitch messages
// - Bit10 enables overtemperature edge messages
// - Bit9 enables non-memory lock messages
// - Enable register 16 bits, reset zero
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module eel_error_log
   import eel_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Error sources
   input wire eel_ecc_s eccErr,
   input wire logic busReqParityErr,
   input wire logic busDataParityErr,
   input wire logic addrStrobeGlitch,
   input wire logic dataStrobeGlitch,
   input wire logic overtempInput,
   input wire logic memOvertemp,
   input wire logic nonMemoryLock,
   // Global system-error enable from command register
   input wire logic serrGlobalEn,
   // Message request to hub interface
   output logic serrMsg,
   // Interrupt
   output logic irq
);
   typedef enum logic [1:0] {
      AP_IDLE = 2'b01,
      AP_DATA = 2'b10
   } eel_ap_e;

   eel_ap_e apState;
   logic [9:0] apAddr;
   logic apWrite;
   logic [15:0] errorReportEnableReg;
   logic singleBitEccFlag;
   logic multiBitEccFlag;
   eel_log_s logReg;
   logic [EVT_W-1:0] irqStatusReg;
   logic [EVT_W-1:0] irqMaskReg;
   logic [EVT_W-1:0] flagEvt;
   logic [EVT_W-1:0] serrArm;
   logic overtempPrev;
   logic ctrlGlobalOverride;
   logic wrStatus;
   logic wrIrqStatus;
   logic sbeCapture;
   logic mbeCapture;
   logic [31:0] rdNext;

   function automatic logic isAddr(input logic [9:0] a, input logic [9:0] ref_a);
      isAddr = (a == ref_a);
   endfunction

   // Address phase capture; always zero wait states
   always_ff @(posedge clock) begin
      if (rst) begin
         apState <= AP_IDLE;
         apAddr <= 10'h000;
         apWrite <= 1'b0;
      end else if (hready) begin
         if (hsel && htrans[1]) begin
            apState <= AP_DATA;
            apAddr <= haddr[9:0];
            apWrite <= hwrite;
         end else begin
            apState <= AP_IDLE;
            apWrite <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   assign wrStatus = (apState == AP_DATA) && apWrite && isAddr(apAddr, ADDR_STATUS);
   assign wrIrqStatus = (apState == AP_DATA) && apWrite && isAddr(apAddr, ADDR_IRQ_STATUS);

   // Enable register, reserved and out-of-window bits kept zero
   always_ff @(posedge clock) begin
      if (rst) begin
         errorReportEnableReg <= ENABLE_RESET;
      end else if ((apState == AP_DATA) && apWrite && isAddr(apAddr, ADDR_ENABLE)) begin
         errorReportEnableReg <= hwdata[15:0] & ENABLE_WMASK_FULL;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         irqMaskReg <= '0;
         ctrlGlobalOverride <= 1'b0;
      end else if ((apState == AP_DATA) && apWrite) begin
         if (isAddr(apAddr, ADDR_IRQ_MASK)) begin
            irqMaskReg <= hwdata[EVT_W-1:0];
         end
         if (isAddr(apAddr, ADDR_CONTROL)) begin
            ctrlGlobalOverride <= hwdata[0];
         end
      end
   end

   // Capture decisions: multi-bit overrides a single-bit lock, nothing overrides a multi-bit lock
   assign mbeCapture = eccErr.valid && eccErr.multiBit && !multiBitEccFlag;
   assign sbeCapture = eccErr.valid && !eccErr.multiBit && !singleBitEccFlag && !multiBitEccFlag;

   // Flags: new event wins over a same-cycle write-one clear
   always_ff @(posedge clock) begin
      if (rst) begin
         singleBitEccFlag <= 1'b0;
         multiBitEccFlag <= 1'b0;
      end else begin
         if (eccErr.valid && !eccErr.multiBit) begin
            singleBitEccFlag <= 1'b1;
         end else if (wrStatus && hwdata[0]) begin
            singleBitEccFlag <= 1'b0;
         end
         if (eccErr.valid && eccErr.multiBit) begin
            multiBitEccFlag <= 1'b1;
         end else if (wrStatus && hwdata[1]) begin
            multiBitEccFlag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         logReg <= '0;
      end else if (mbeCapture || sbeCapture) begin
         logReg.addr <= eccErr.addr;
         logReg.chan <= eccErr.chan;
         logReg.dev <= eccErr.dev;
         logReg.etype <= mbeCapture ? ETYPE_MULTI : ETYPE_SINGLE;
      end
   end

   // Flag-set events: ECC on a rising flag, overtempInput on its rising edge, other sources every cycle they are high
   always_ff @(posedge clock) begin
      if (rst) begin
         overtempPrev <= 1'b0;
      end else begin
         overtempPrev <= overtempInput;
      end
   end

   always_comb begin
      flagEvt = '0;
      flagEvt[EV_SBE] = eccErr.valid && !eccErr.multiBit && !singleBitEccFlag;
      flagEvt[EV_MBE] = eccErr.valid && eccErr.multiBit && !multiBitEccFlag;
      flagEvt[EV_RPAR] = busReqParityErr;
      flagEvt[EV_DPAR] = busDataParityErr;
      flagEvt[EV_ASTB] = addrStrobeGlitch;
      flagEvt[EV_DSTB] = dataStrobeGlitch;
      flagEvt[EV_THERM] = (overtempInput && !overtempPrev) || memOvertemp;
      flagEvt[EV_LOCK] = nonMemoryLock;
   end

   always_comb begin
      serrArm = '0;
      serrArm[EV_SBE] = errorReportEnableReg[EN_SBE];
      serrArm[EV_MBE] = errorReportEnableReg[EN_MBE];
      serrArm[EV_RPAR] = errorReportEnableReg[EN_RPAR];
      serrArm[EV_DPAR] = errorReportEnableReg[EN_DPAR];
      serrArm[EV_ASTB] = errorReportEnableReg[EN_ASTB];
      serrArm[EV_DSTB] = errorReportEnableReg[EN_DSTB];
      serrArm[EV_THERM] = errorReportEnableReg[EN_THERM];
      serrArm[EV_LOCK] = errorReportEnableReg[EN_LOCK];
   end

   // One-cycle message request; simultaneous events merge into one message
   always_ff @(posedge clock) begin
      if (rst) begin
         serrMsg <= 1'b0;
      end else begin
         // Control bit is storage only: the global enable alone may open the message path
         serrMsg <= serrGlobalEn && |(flagEvt & serrArm);
      end
   end

   // Sticky interrupt status, set beats write-one clear
   always_ff @(posedge clock) begin
      if (rst) begin
         irqStatusReg <= '0;
      end else begin
         irqStatusReg <= (irqStatusReg & ~(wrIrqStatus ? hwdata[EVT_W-1:0] : '0)) | flagEvt;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStatusReg & irqMaskReg);
      end
   end

   // Read data: registered in the address phase so it stands in the data phase
   always_comb begin
      rdNext = 32'h0000_0000;
      unique case (haddr[9:0])
         ADDR_STATUS: rdNext = {30'h0000_0000, multiBitEccFlag, singleBitEccFlag};
         ADDR_ENABLE: rdNext = {16'h0000, errorReportEnableReg};
         ADDR_LOG_ADDR: rdNext = logReg.addr;
         ADDR_LOG_INFO: rdNext = {16'h0000, 6'h00, logReg.etype, logReg.chan, logReg.dev};
         ADDR_CONTROL: rdNext = {31'h0000_0000, ctrlGlobalOverride};
         ADDR_IRQ_STATUS: rdNext = {24'h00_0000, irqStatusReg};
         ADDR_IRQ_MASK: rdNext = {24'h00_0000, irqMaskReg};
         default: rdNext = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         hrdata <= rdNext;
      end
   end
endmodule
`default_nettype wire

// ### tb/eel_error_log_properties.sv
`timescale 1ns/100ps
`default_nettype none
module eel_error_log_properties
   import eel_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   // Events
   input wire eel_ecc_s eccErr,
   input wire logic busReqParityErr,
   input wire logic busDataParityErr,
   input wire logic addrStrobeGlitch,
   input wire logic dataStrobeGlitch,
   input wire logic overtempInput,
   input wire logic memOvertemp,
   input wire logic nonMemoryLock,
   // Message
   input wire logic serrGlobalEn,
   input wire logic serrMsg
);
   logic [15:0] enReg;
   logic wrReg;
   logic tempReg;
   logic cause;
   // Enables mirrored from bus writes, since the ports hide them
   always_ff @(posedge clock) begin
      if (rst) begin
         enReg <= 16'h0000;
         wrReg <= 1'b0;
         tempReg <= 1'b0;
      end else begin
         wrReg <= hready && hsel && htrans[1] && hwrite && haddr[9:0] == ADDR_ENABLE;
         tempReg <= overtempInput;
         if (wrReg) begin
            enReg <= hwdata[15:0] & ENABLE_WMASK_FULL;
         end
      end
   end
   assign cause = (busReqParityErr && enReg[15]) || (busDataParityErr && enReg[14])
      || (addrStrobeGlitch && enReg[13]) || (dataStrobeGlitch && enReg[12]) || (nonMemoryLock && enReg[9])
      || ((memOvertemp || (overtempInput && !tempReg)) && enReg[10]) || (eccErr.valid && enReg[1:0] != 2'b00);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   a_rpar_msg: assert property (busReqParityErr && enReg[15] && serrGlobalEn |-> ##[1:2] serrMsg)
      else $error("request parity message missing");
   a_dpar_msg: assert property (busDataParityErr && enReg[14] && serrGlobalEn |-> ##[1:2] serrMsg)
      else $error("data parity message missing");
   a_astb_msg: assert property (addrStrobeGlitch && enReg[13] && serrGlobalEn |-> ##[1:2] serrMsg)
      else $error("address strobe message missing");
   a_dstb_msg: assert property (dataStrobeGlitch && enReg[12] && serrGlobalEn |-> ##[1:2] serrMsg)
      else $error("data strobe message missing");
   a_temp_msg: assert property (memOvertemp && enReg[10] && serrGlobalEn |-> ##[1:2] serrMsg)
      else $error("memory overtemp message missing");
   a_temp_edge: assert property ($rose(overtempInput) && enReg[10] && serrGlobalEn |-> ##[1:2] serrMsg)
      else $error("overtemp edge message missing");
   a_lock_msg: assert property (nonMemoryLock && enReg[9] && serrGlobalEn |-> ##[1:2] serrMsg)
      else $error("lock message missing");
   a_msg_cause: assert property (serrMsg |-> $past(cause) || $past(cause, 2))
      else $error("message without enabled cause");
   a_msg_global: assert property (serrMsg |-> $past(serrGlobalEn))
      else $error("message without global enable");
endmodule
bind eel_error_log eel_error_log_properties chk_u (.*);
`default_nettype wire

// ### tb/eel_hub_sink.sv
`timescale 1ns/100ps
`default_nettype none
module eel_hub_sink (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Message
   input wire logic serrMsg,
   output logic [7:0] msgCount
);
   // Hub has no back-pressure, so every request pulse is one message
   always_ff @(posedge clock) begin
      if (rst) begin
         msgCount <= 8'h00;
      end else if (serrMsg) begin
         msgCount <= msgCount + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ### tb/tb_memory_ecc_error_log_and_serr_enable.sv
`timescale 1ns/100ps
`default_nettype none
module tb_memory_ecc_error_log_and_serr_enable
   import eel_pkg::*;
;
   logic clock, rst, hwrite, hreadyout, hresp, serrGlobalEn, serrMsg, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [6:0] ev;
   logic [7:0] msgCount;
   eel_ecc_s eccErr;
   int fails, testsRun, expMsg;
   int enBit[7] = '{15, 14, 13, 12, 10, 10, 9};
   eel_error_log dut_u (.clock(clock), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .eccErr(eccErr), .busReqParityErr(ev[0]), .busDataParityErr(ev[1]),
      .addrStrobeGlitch(ev[2]), .dataStrobeGlitch(ev[3]), .memOvertemp(ev[4]), .overtempInput(ev[5]),
      .nonMemoryLock(ev[6]), .serrGlobalEn(serrGlobalEn), .serrMsg(serrMsg), .irq(irq));
   eel_hub_sink hub_u (.clock(clock), .rst(rst), .serrMsg(serrMsg), .msgCount(msgCount));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", testsRun, fails);
      if (fails == 0 && testsRun > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      testsRun++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic waitRdy();
      int n;
      n = 0;
      @(posedge clock);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            fails++;
            results();
         end
         @(posedge clock);
      end
   endtask
   task automatic busOp(input logic [9:0] a, input logic w, input logic [31:0] d);
      htrans <= 2'b10;
      haddr <= {22'h00_0000, a};
      hwrite <= w;
      waitRdy();
      htrans <= 2'b00;
      hwdata <= d;
      waitRdy();
      rd = hrdata;
   endtask
   task automatic rdChk(input logic [9:0] a, input logic [31:0] e, input string nm);
      busOp(a, 1'b0, 32'h0000_0000);
      chk(nm, e, rd);
   endtask
   task automatic cntChk();
      chk("message count", 32'(expMsg), {24'h00_0000, msgCount});
   endtask
   task automatic fire(input logic [6:0] v);
      ev <= v;
      @(posedge clock);
      ev <= 7'h00;
      repeat (4) @(posedge clock);
   endtask
   task automatic ecc(input logic mb, input logic [31:0] a);
      eccErr <= {1'b1, mb, a, a[7:0]};
      @(posedge clock);
      eccErr.valid <= 1'b0;
      repeat (4) @(posedge clock);
   endtask
   initial begin
      rst = 1'b1;
      {htrans, haddr, hwrite, hwdata, ev, serrGlobalEn} = '0;
      eccErr = '0;
      {fails, testsRun, expMsg} = '0;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rdChk(ADDR_ENABLE, 32'h0000_0000, "enable reset");
      busOp(ADDR_ENABLE, 1'b1, 32'hFFFF_FFFF);
      rdChk(ADDR_ENABLE, 32'h0000_F603, "enable bits");
      busOp(10'h3FC, 1'b1, 32'hFFFF_FFFF);
      rdChk(10'h3FC, 32'h0000_0000, "unmapped");
      serrGlobalEn <= 1'b1;
      for (int k = 0; k < 7; k++) begin
         busOp(ADDR_ENABLE, 1'b1, 32'h0000_0001 << enBit[k]);
         fire(7'h01 << k);
         expMsg++;
         cntChk();
         busOp(ADDR_ENABLE, 1'b1, 32'h0000_F603 ^ (32'h0000_0001 << enBit[k]));
         fire(7'h01 << k);
         cntChk();
      end
      serrGlobalEn <= 1'b0;
      busOp(ADDR_ENABLE, 1'b1, 32'h0000_F603);
      fire(7'h7F);
      cntChk();
      busOp(ADDR_CONTROL, 1'b1, 32'h0000_0001);
      rdChk(ADDR_CONTROL, 32'h0000_0001, "control");
      fire(7'h01);
      cntChk();
      busOp(ADDR_CONTROL, 1'b1, 32'h0000_0000);
      serrGlobalEn <= 1'b1;
      ecc(1'b0, 32'h1234_5678);
      expMsg++;
      rdChk(ADDR_STATUS, 32'h0000_0001, "status");
      rdChk(ADDR_LOG_ADDR, 32'h1234_5678, "log addr");
      rdChk(ADDR_LOG_INFO, 32'h0000_0178, "log info");
      ecc(1'b0, 32'hAAAA_5555);
      rdChk(ADDR_LOG_ADDR, 32'h1234_5678, "log addr");
      cntChk();
      ecc(1'b1, 32'h0BAD_F00D);
      expMsg++;
      rdChk(ADDR_STATUS, 32'h0000_0003, "status");
      rdChk(ADDR_LOG_ADDR, 32'h0BAD_F00D, "log addr");
      rdChk(ADDR_LOG_INFO, 32'h0000_020D, "log info");
      ecc(1'b1, 32'h5A5A_0000);
      rdChk(ADDR_LOG_ADDR, 32'h0BAD_F00D, "log addr");
      cntChk();
      busOp(ADDR_STATUS, 1'b1, 32'h0000_0001);
      rdChk(ADDR_STATUS, 32'h0000_0002, "status");
      busOp(ADDR_STATUS, 1'b1, 32'h0000_0000);
      rdChk(ADDR_STATUS, 32'h0000_0002, "status");
      busOp(ADDR_STATUS, 1'b1, 32'h0000_0002);
      rdChk(ADDR_STATUS, 32'h0000_0000, "status");
      ecc(1'b0, 32'h0000_0042);
      expMsg++;
      rdChk(ADDR_LOG_ADDR, 32'h0000_0042, "log addr");
      cntChk();
      busOp(ADDR_IRQ_MASK, 1'b1, 32'h0000_0000);
      busOp(ADDR_IRQ_STATUS, 1'b1, 32'h0000_00FF);
      fire(7'h01);
      expMsg++;
      rdChk(ADDR_IRQ_STATUS, 32'h0000_0004, "irq status");
      chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
      busOp(ADDR_IRQ_MASK, 1'b1, 32'h0000_0004);
      repeat (3) @(posedge clock);
      chk("irq raised", 32'h0000_0001, {31'h0000_0000, irq});
      busOp(ADDR_IRQ_STATUS, 1'b1, 32'h0000_0004);
      repeat (3) @(posedge clock);
      chk("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
      cntChk();
      chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
      results();
   end
endmodule
`default_nettype wire
